// file: rcfs_pkg.sv
// Package: register map, field positions and reset values of the reset cause and fault status block
package rcfs_pkg;
  // APB address width and register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] BOR_CTL_OFF = 12'h030;
  localparam logic [ADDR_W-1:0] INT_MASK_OFF = 12'h054;
  localparam logic [ADDR_W-1:0] FAULT_STAT_OFF = 12'h058;
  localparam logic [ADDR_W-1:0] RESET_CAUSE_OFF = 12'h05c;
  // Fault status and mask layout (same positions in both registers)
  localparam int STAT_W = 7;
  localparam int BOR_BIT = 1;
  localparam int LDO_BIT = 2;
  localparam int MOF_BIT = 3;
  localparam int IOF_BIT = 4;
  localparam int PLL_BIT = 6;
  localparam logic [STAT_W-1:0] STAT_USED = 7'h5e;
  localparam logic [STAT_W-1:0] STAT_RST = 7'h00;
  // Brown-out control: interrupt (0) or reset (1) select
  localparam int BOR_SEL_BIT = 1;
  localparam logic [1:0] BOR_CTL_RST = 2'h0;
  // Reset cause layout
  localparam int CAUSE_W = 6;
  localparam int EXT_BIT = 0;
  localparam int POR_BIT = 1;
  localparam int BORR_BIT = 2;
  localparam int WDOG_BIT = 3;
  localparam int SWR_BIT = 4;
  localparam int LDOR_BIT = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_POR_VAL = 6'h02;
  localparam logic [CAUSE_W-1:0] CAUSE_EXT_VAL = 6'h01;
  // Synchronised input vector: five faults then five reset sources
  localparam int NUM_IN = 10;
  localparam int IN_BOR = 0;
  localparam int IN_LDO = 1;
  localparam int IN_MOF = 2;
  localparam int IN_IOF = 3;
  localparam int IN_PLL = 4;
  localparam int IN_EXT = 5;
  localparam int IN_BORR = 6;
  localparam int IN_WDT = 7;
  localparam int IN_SWR = 8;
  localparam int IN_LDOR = 9;
endpackage : rcfs_pkg

// file: rcfs_lvl_if.sv
// Interface: filtered input levels passed from the synchroniser to the core
`timescale 1ns/100ps
`default_nettype none
interface rcfs_lvl_if #(parameter int W = 1);
  logic [W-1:0] level;
  // Synchroniser drives, core reads
  modport src (output level);
  modport dst (input level);
endinterface : rcfs_lvl_if
`default_nettype wire

// file: rcfs_sync.sv
// Module: three-flop synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module rcfs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous inputs
  input wire logic [W-1:0] async_in,
  // Filtered levels
  rcfs_lvl_if.src lvl
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] filt_reg;
  logic [W-1:0] agree;
  logic [W-1:0] filt_next;

  // Only the second and third stages are compared; first stage may be metastable
  assign agree = ~(s2_reg ^ s3_reg);
  assign filt_next = (filt_reg & ~agree) | (s3_reg & agree);
  assign lvl.level = filt_reg;

  // Shift chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end
endmodule : rcfs_sync
`default_nettype wire

// file: rcfs_top.sv
// Module: reset cause register and masked fault status with an APB slave
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1: Oscillator faults set their masked status flags
// R2: Unregulated regulator sets status bit 2
// R3: Detected brown-out sets status bit 1
// R4: Brown-out reported only if masked, interrupt-selected
// R5: Writing one clears status flag; zero keeps
// R6: Cause register shows reset source, not constant
// R7: Pin reset sets bit 0, clears others
// R8: Other sources accumulate on earlier flags
// R9: Regulator-loss reset sets cause bit 5
// R10: Software reset sets cause bit 4
// R11: Watchdog reset sets cause bit 3
// R12: Brown-out reset sets cause bit 2
// R13: Power-on reset sets cause bit 1
// R14: Pin reset sets cause bit 0
// R15: PLL ready sets bit 6, one clears
// R16: Cause writable; bits 31:6 read zero
module rcfs_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [rcfs_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fault detectors (asynchronous levels)
  input wire logic brownout_det,
  input wire logic regulator_unreg,
  input wire logic main_osc_fault,
  input wire logic internal_osc_fault,
  input wire logic pll_ready_expired,
  // Reset sources (asynchronous, high while the source fires)
  input wire logic ext_pin_reset,
  input wire logic brownout_reset,
  input wire logic watchdog_reset,
  input wire logic software_reset,
  input wire logic regulator_reset,
  // Brown-out routed to reset instead of interrupt
  output logic brownout_reset_req
);
  // Address match on an aligned word
  function automatic logic word_hit(input logic [rcfs_pkg::ADDR_W-1:0] a,
                                    input logic [rcfs_pkg::ADDR_W-1:0] off);
    word_hit = (a[rcfs_pkg::ADDR_W-1:2] == off[rcfs_pkg::ADDR_W-1:2]);
  endfunction : word_hit

  rcfs_lvl_if #(.W(rcfs_pkg::NUM_IN)) lvl_if ();

  logic [rcfs_pkg::NUM_IN-1:0] pins;
  logic [rcfs_pkg::NUM_IN-1:0] lvl;
  logic [rcfs_pkg::NUM_IN-1:0] prev_reg;
  logic [rcfs_pkg::NUM_IN-1:0] rise;
  logic [rcfs_pkg::STAT_W-1:0] status_reg;
  logic [rcfs_pkg::STAT_W-1:0] status_next;
  logic [rcfs_pkg::STAT_W-1:0] mask_reg;
  logic [rcfs_pkg::STAT_W-1:0] mask_next;
  logic [rcfs_pkg::STAT_W-1:0] stat_set;
  logic [rcfs_pkg::STAT_W-1:0] stat_clr;
  logic [1:0] bor_ctl_reg;
  logic [1:0] bor_ctl_next;
  logic [rcfs_pkg::CAUSE_W-1:0] cause_reg;
  logic [rcfs_pkg::CAUSE_W-1:0] cause_next;
  logic [rcfs_pkg::CAUSE_W-1:0] cause_base;
  logic [rcfs_pkg::CAUSE_W-1:0] cause_set;
  logic [31:0] rdata_next;
  logic hit_bor;
  logic hit_mask;
  logic hit_stat;
  logic hit_cause;
  logic mapped;
  logic setup_rd;
  logic wr_en;
  logic bor_int_sel;
  logic ext_rise;

  // Pin inputs into the synchroniser
  assign pins = {regulator_reset, software_reset, watchdog_reset, brownout_reset, ext_pin_reset,
                 pll_ready_expired, internal_osc_fault, main_osc_fault, regulator_unreg, brownout_det};

  rcfs_sync #(.W(rcfs_pkg::NUM_IN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins),
    .lvl(lvl_if.src)
  );

  assign lvl = lvl_if.level;
  // Reset sources count once per assertion, so take rising edges
  assign rise = lvl & ~prev_reg;
  assign ext_rise = rise[rcfs_pkg::IN_EXT];

  // APB decode; zero wait states, error on unmapped word
  assign hit_bor = word_hit(paddr, rcfs_pkg::BOR_CTL_OFF);
  assign hit_mask = word_hit(paddr, rcfs_pkg::INT_MASK_OFF);
  assign hit_stat = word_hit(paddr, rcfs_pkg::FAULT_STAT_OFF);
  assign hit_cause = word_hit(paddr, rcfs_pkg::RESET_CAUSE_OFF);
  assign mapped = hit_bor | hit_mask | hit_stat | hit_cause;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_en = psel & penable & pwrite & mapped;

  // Read mux; unused upper bits read zero
  // R16: upper bits zero
  assign rdata_next = hit_cause ? {{(32 - rcfs_pkg::CAUSE_W){1'b0}}, cause_reg} :
                      hit_stat ? {{(32 - rcfs_pkg::STAT_W){1'b0}}, status_reg} :
                      hit_mask ? {{(32 - rcfs_pkg::STAT_W){1'b0}}, mask_reg} :
                      hit_bor ? {30'h0000_0000, bor_ctl_reg} : 32'h0000_0000;

  // Brown-out select: cleared means interrupt, set means reset request
  assign bor_int_sel = ~bor_ctl_reg[rcfs_pkg::BOR_SEL_BIT];
  assign brownout_reset_req = lvl[rcfs_pkg::IN_BOR] & bor_ctl_reg[rcfs_pkg::BOR_SEL_BIT];

  // Control registers, used bits only
  assign mask_next = (wr_en & hit_mask) ? (pwdata[rcfs_pkg::STAT_W-1:0] & rcfs_pkg::STAT_USED) : mask_reg;
  assign bor_ctl_next = (wr_en & hit_bor) ? {pwdata[rcfs_pkg::BOR_SEL_BIT], 1'b0} : bor_ctl_reg;

  // Fault flags gated by the mask; a still-present fault re-sets after clearing
  // R1: oscillator fault flags
  assign stat_set[rcfs_pkg::MOF_BIT] = lvl[rcfs_pkg::IN_MOF] & mask_reg[rcfs_pkg::MOF_BIT];
  assign stat_set[rcfs_pkg::IOF_BIT] = lvl[rcfs_pkg::IN_IOF] & mask_reg[rcfs_pkg::IOF_BIT];
  // R2: regulator loss flag
  assign stat_set[rcfs_pkg::LDO_BIT] = lvl[rcfs_pkg::IN_LDO] & mask_reg[rcfs_pkg::LDO_BIT];
  // R3: brown-out flag
  // R4: mask and select gate
  assign stat_set[rcfs_pkg::BOR_BIT] = lvl[rcfs_pkg::IN_BOR] & mask_reg[rcfs_pkg::BOR_BIT] & bor_int_sel;
  // R15: PLL ready flag
  assign stat_set[rcfs_pkg::PLL_BIT] = lvl[rcfs_pkg::IN_PLL] & mask_reg[rcfs_pkg::PLL_BIT];
  assign stat_set[0] = 1'b0;
  assign stat_set[5] = 1'b0;

  // R5: write one clears
  assign stat_clr = (wr_en & hit_stat) ? pwdata[rcfs_pkg::STAT_W-1:0] : '0;
  // Set beats clear so an event during the write is kept
  assign status_next = ((status_reg & ~stat_clr) | stat_set) & rcfs_pkg::STAT_USED;

  // Software may rewrite the cause bits; later events still land on top
  // R16: cause writable
  assign cause_base = (wr_en & hit_cause) ? pwdata[rcfs_pkg::CAUSE_W-1:0] : cause_reg;
  // R9: regulator-loss cause
  assign cause_set[rcfs_pkg::LDOR_BIT] = rise[rcfs_pkg::IN_LDOR];
  // R10: software cause
  assign cause_set[rcfs_pkg::SWR_BIT] = rise[rcfs_pkg::IN_SWR];
  // R11: watchdog cause
  assign cause_set[rcfs_pkg::WDOG_BIT] = rise[rcfs_pkg::IN_WDT];
  // R12: brown-out cause
  assign cause_set[rcfs_pkg::BORR_BIT] = rise[rcfs_pkg::IN_BORR];
  // Power-on is only seen through presetn
  assign cause_set[rcfs_pkg::POR_BIT] = 1'b0;
  assign cause_set[rcfs_pkg::EXT_BIT] = 1'b0;
  // R7: pin reset clears others
  // R14: pin cause
  // R8: other causes accumulate
  assign cause_next = ext_rise ? rcfs_pkg::CAUSE_EXT_VAL : (cause_base | cause_set);

  // Edge history and read data capture in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= '0;
      prdata <= 32'h0000_0000;
    end else begin
      prev_reg <= lvl;
      prdata <= setup_rd ? rdata_next : prdata;
    end
  end

  // Fault status and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= rcfs_pkg::STAT_RST;
      mask_reg <= rcfs_pkg::STAT_RST;
      bor_ctl_reg <= rcfs_pkg::BOR_CTL_RST;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      bor_ctl_reg <= bor_ctl_next;
    end
  end

  // Cause register; presetn is the power-on reset of this always-on logic
  // R6: source, not constant
  // R13: power-on cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= rcfs_pkg::CAUSE_POR_VAL;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // Checks on the logic above
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  osc_fault_set_a: assert property ( // R1
    (lvl[rcfs_pkg::IN_MOF] && mask_reg[rcfs_pkg::MOF_BIT]) |=> status_reg[rcfs_pkg::MOF_BIT])
    else $error("main oscillator fault flag not set");

  iosc_fault_set_a: assert property ( // R1
    (lvl[rcfs_pkg::IN_IOF] && mask_reg[rcfs_pkg::IOF_BIT]) |=> status_reg[rcfs_pkg::IOF_BIT])
    else $error("internal oscillator fault flag not set");

  reg_loss_set_a: assert property ( // R2
    (lvl[rcfs_pkg::IN_LDO] && mask_reg[rcfs_pkg::LDO_BIT]) |=> status_reg[rcfs_pkg::LDO_BIT])
    else $error("regulator loss flag not set");

  bor_flag_set_a: assert property ( // R3
    (lvl[rcfs_pkg::IN_BOR] && mask_reg[rcfs_pkg::BOR_BIT] && bor_int_sel) |=> status_reg[rcfs_pkg::BOR_BIT])
    else $error("brown-out flag not set");

  bor_gate_a: assert property ( // R4
    ($rose(status_reg[rcfs_pkg::BOR_BIT])) |-> ($past(mask_reg[rcfs_pkg::BOR_BIT]) && $past(bor_int_sel)))
    else $error("brown-out flag set while masked or reset-selected");

  w1c_clear_a: assert property ( // R5
    (wr_en && hit_stat && pwdata[rcfs_pkg::MOF_BIT] && !stat_set[rcfs_pkg::MOF_BIT])
    |=> !status_reg[rcfs_pkg::MOF_BIT])
    else $error("write one did not clear flag");

  w0_keep_a: assert property ( // R5
    (wr_en && hit_stat && !pwdata[rcfs_pkg::LDO_BIT] && status_reg[rcfs_pkg::LDO_BIT])
    |=> status_reg[rcfs_pkg::LDO_BIT])
    else $error("write zero disturbed flag");

  ext_clear_a: assert property ( // R7
    ext_rise |=> (cause_reg == rcfs_pkg::CAUSE_EXT_VAL)
    ##1 (cause_reg[rcfs_pkg::EXT_BIT] || ($past(wr_en) && $past(hit_cause))))
    else $error("pin reset did not leave only bit 0");

  cause_sticky_a: assert property ( // R8
    (!ext_rise && !(wr_en && hit_cause)) |=> ((cause_reg & $past(cause_reg)) == $past(cause_reg)))
    else $error("reset cause flag lost");

  ldo_cause_a: assert property ( // R9
    (rise[rcfs_pkg::IN_LDOR] && !ext_rise) |=> cause_reg[rcfs_pkg::LDOR_BIT])
    else $error("regulator reset cause not set");

  soft_cause_a: assert property ( // R10
    (rise[rcfs_pkg::IN_SWR] && !ext_rise) |=> cause_reg[rcfs_pkg::SWR_BIT])
    else $error("software reset cause not set");

  wdog_cause_a: assert property ( // R11
    (rise[rcfs_pkg::IN_WDT] && !ext_rise) |=> cause_reg[rcfs_pkg::WDOG_BIT])
    else $error("watchdog reset cause not set");

  bor_cause_a: assert property ( // R12
    (rise[rcfs_pkg::IN_BORR] && !ext_rise) |=> cause_reg[rcfs_pkg::BORR_BIT])
    else $error("brown-out reset cause not set");

  pll_flag_a: assert property ( // R15
    (lvl[rcfs_pkg::IN_PLL] && mask_reg[rcfs_pkg::PLL_BIT]) |=> status_reg[rcfs_pkg::PLL_BIT])
    else $error("PLL ready flag not set");

  cause_read_a: assert property ( // R16
    (setup_rd && hit_cause)
    |=> (prdata[31:rcfs_pkg::CAUSE_W] == '0 && prdata[rcfs_pkg::CAUSE_W-1:0] == $past(cause_reg)))
    else $error("reset cause read data wrong");

  // Gating, clearing and reset-value checks
  // Negative checks matter: a flag that sets too eagerly
  // would still pass every positive check above
  bor_mask_off_a: assert property ( // R4
    (!mask_reg[rcfs_pkg::BOR_BIT] && !status_reg[rcfs_pkg::BOR_BIT])
    |=> !status_reg[rcfs_pkg::BOR_BIT])
    else $error("brown-out flag set while masked");

  bor_select_a: assert property ( // R4
    (bor_ctl_reg[rcfs_pkg::BOR_SEL_BIT] && !status_reg[rcfs_pkg::BOR_BIT])
    |=> !status_reg[rcfs_pkg::BOR_BIT])
    else $error("brown-out flag set while reset selected");

  reg_loss_src_a: assert property ( // R2
    $rose(status_reg[rcfs_pkg::LDO_BIT]) |-> ($past(lvl[rcfs_pkg::IN_LDO]) && $past(mask_reg[rcfs_pkg::LDO_BIT])))
    else $error("regulator loss flag set without its source");

  iosc_keep_a: assert property ( // R5
    (wr_en && hit_stat && !pwdata[rcfs_pkg::IOF_BIT] && status_reg[rcfs_pkg::IOF_BIT])
    |=> status_reg[rcfs_pkg::IOF_BIT])
    else $error("write zero disturbed internal oscillator flag");

  pll_clear_a: assert property ( // R15
    (wr_en && hit_stat && pwdata[rcfs_pkg::PLL_BIT] && !stat_set[rcfs_pkg::PLL_BIT])
    |=> !status_reg[rcfs_pkg::PLL_BIT])
    else $error("write one did not clear PLL ready flag");

  cause_write_a: assert property ( // R16
    (wr_en && hit_cause && (rise == '0))
    |=> (cause_reg == $past(pwdata[rcfs_pkg::CAUSE_W-1:0])))
    else $error("reset cause write not stored");

  por_cause_a: assert property ( // R13
    $rose(presetn) |-> (cause_reg == rcfs_pkg::CAUSE_POR_VAL))
    else $error("power-on cause missing after reset");

  // Main scenarios
  ext_seen_c: cover property (ext_rise ##1 cause_reg == rcfs_pkg::CAUSE_EXT_VAL);
  bor_flag_c: cover property ($rose(status_reg[rcfs_pkg::BOR_BIT]));
  w1c_done_c: cover property (wr_en && hit_stat ##1 $fell(status_reg[rcfs_pkg::MOF_BIT]));
  multi_cause_c: cover property (cause_reg[rcfs_pkg::WDOG_BIT] && cause_reg[rcfs_pkg::SWR_BIT]);
  pll_flag_c: cover property ($rose(status_reg[rcfs_pkg::PLL_BIT]));
endmodule : rcfs_top
`default_nettype wire

// file: tb_reset_cause_and_fault_status.sv
// Testbench: self-checking bench for the reset cause and fault status block
`timescale 1ns/100ps
`default_nettype none
module tb_reset_cause_and_fault_status;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic brownout_reset_req;
  // Fault levels: brown-out, regulator, main osc, internal osc, PLL ready
  logic [4:0] flt = 5'h00;
  // Reset sources: watchdog, software, brown-out, regulator, pin
  logic [4:0] rsrc = 5'h00;
  logic [32:0] rq[$];
  logic [32:0] e;
  integer fail_count = 0;
  integer n_tests = 0;
  integer seed = 32'hbe18;
  integer i;
  logic [31:0] x;
  logic [31:0] d;
  int fbit[5] = '{rcfs_pkg::BOR_BIT, rcfs_pkg::LDO_BIT, rcfs_pkg::MOF_BIT, rcfs_pkg::IOF_BIT, rcfs_pkg::PLL_BIT};
  int cbit[4] = '{rcfs_pkg::WDOG_BIT, rcfs_pkg::SWR_BIT, rcfs_pkg::BORR_BIT, rcfs_pkg::LDOR_BIT};

  // 250 MHz clock
  always #2 pclk = ~pclk;

  rcfs_top DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brownout_det(flt[0]), .regulator_unreg(flt[1]), .main_osc_fault(flt[2]),
    .internal_osc_fault(flt[3]), .pll_ready_expired(flt[4]),
    .watchdog_reset(rsrc[0]), .software_reset(rsrc[1]), .brownout_reset(rsrc[2]),
    .regulator_reset(rsrc[3]), .ext_pin_reset(rsrc[4]), .brownout_reset_req(brownout_reset_req)
  );

  task end_sim;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask : end_sim

  // One APB transfer; the expected answer is queued for the monitor
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] ex);
    integer n;
    begin
      n = 0;
      rq.push_back(ex);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n >= 50) begin
        fail_count = fail_count + 1;
        end_sim();
      end else begin
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
      end
    end
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, 33'h000000000);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] ex);
    xfer(1'b0, a, 32'h00000000, {1'b0, ex});
  endtask : rd

  // Hold an input high long enough to pass the filter, then drop it
  task pulse(input logic is_rst, input int k);
    begin
      if (is_rst) rsrc[k] <= 1'b1;
      else flt[k] <= 1'b1;
      repeat (8) @(posedge pclk);
      if (is_rst) rsrc[k] <= 1'b0;
      else flt[k] <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask : pulse

  // Monitor: each completed transfer takes the oldest note; writes check only the error flag
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      e = (rq.size() > 0) ? rq.pop_front() : 33'h1ffffffff;
      n_tests = n_tests + 1;
      if ({pslverr, (pwrite ? e[31:0] : prdata)} !== e) begin
        $display("BAD apb addr %h expected %h seen %h", paddr, e, {pslverr, prdata});
        fail_count = fail_count + 1;
      end
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count = fail_count + 1;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(rcfs_pkg::RESET_CAUSE_OFF, 32'h00000002);
    // Brown-out while its mask bit is clear leaves no flag
    pulse(1'b0, 0);
    rd(rcfs_pkg::FAULT_STAT_OFF, 32'h00000000);
    wr(rcfs_pkg::INT_MASK_OFF, 32'h0000005e);
    // Each fault in turn sets its own status bit
    x = 32'h0;
    for (i = 0; i < 5; i++) begin
      pulse(1'b0, i);
      x[fbit[i]] = 1'b1;
      rd(rcfs_pkg::FAULT_STAT_OFF, x);
    end
    wr(rcfs_pkg::FAULT_STAT_OFF, 32'h00000000);
    rd(rcfs_pkg::FAULT_STAT_OFF, x);
    wr(rcfs_pkg::FAULT_STAT_OFF, 32'h00000012);
    rd(rcfs_pkg::FAULT_STAT_OFF, x & ~32'h12);
    wr(rcfs_pkg::FAULT_STAT_OFF, 32'h0000007f);
    rd(rcfs_pkg::FAULT_STAT_OFF, 32'h00000000);
    // Brown-out routed to reset: no status flag, request raised instead
    wr(rcfs_pkg::BOR_CTL_OFF, 32'h00000002);
    flt[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    n_tests = n_tests + 1;
    if (brownout_reset_req !== 1'b1) begin
      $display("BAD brownout_reset_req expected 1 seen %b", brownout_reset_req);
      fail_count = fail_count + 1;
    end
    flt[0] <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(rcfs_pkg::FAULT_STAT_OFF, 32'h00000000);
    wr(rcfs_pkg::BOR_CTL_OFF, 32'h00000000);
    // Causes accumulate, then the pin reset wipes them
    wr(rcfs_pkg::RESET_CAUSE_OFF, 32'h00000000);
    rd(rcfs_pkg::RESET_CAUSE_OFF, 32'h00000000);
    x = 32'h0;
    for (i = 0; i < 4; i++) begin
      pulse(1'b1, i);
      x[cbit[i]] = 1'b1;
      rd(rcfs_pkg::RESET_CAUSE_OFF, x);
    end
    pulse(1'b1, 4);
    rd(rcfs_pkg::RESET_CAUSE_OFF, 32'h00000001);
    // Random writes: upper bits always read zero
    repeat (4) begin
      d = $random(seed);
      wr(rcfs_pkg::RESET_CAUSE_OFF, d);
      rd(rcfs_pkg::RESET_CAUSE_OFF, d & 32'h3f);
    end
    // Unmapped word is refused and changes nothing
    xfer(1'b1, 12'h100, 32'hffffffff, 33'h100000000);
    xfer(1'b0, 12'h100, 32'h00000000, 33'h100000000);
    rd(rcfs_pkg::RESET_CAUSE_OFF, d & 32'h3f);
    // Second power-on reset mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(rcfs_pkg::RESET_CAUSE_OFF, 32'h00000002);
    end_sim();
  end
endmodule : tb_reset_cause_and_fault_status
`default_nettype wire
